// ==== hw/tr_timing_top.sv ====
// Timing reference, failure reporting and frame pulse generator
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module tr_timing_top #(
  parameter int REF_TIMEOUT_CYC = tr_pkg::REF_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // AXI4-Lite write
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Timing inputs
  input wire logic [3:0] i_timing_reference_inputs,
  input wire logic i_oscillator_present,
  input wire logic [1:0] i_four_meg_clock_select,
  input wire logic i_frame_pulse_input,
  // Timing outputs
  output logic [3:0] o_reference_failure_outputs,
  output logic [5:0] o_generated_clock_outputs,
  output logic [3:0] o_frame_pulse_outputs,
  output logic [1:0] o_selected_ref,
  output logic o_master_clk_from_osc,
  output logic o_irq
);

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] ck3_sel;
    logic ck4_sel;
    logic sle;
    logic [1:0] pref;
    logic force_ref;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [13:0] frame_cnt;
    logic fpi_prev;
    logic [7:0] fpi_hi;
    logic [7:0] fpi_width;
    logic [5:0][31:0] acc;
    logic [5:0] clk_out;
    logic [3:0][15:0] fp_cnt;
    logic [3:0] fp_out;
    logic loop_on;
    logic [3:0] fail_prev;
    logic [3:0] fail_out;
    logic [1:0] sel;
    logic osc_src;
    logic irq;
  } tr_top_s;

  tr_top_s st;
  tr_top_s next_st;

  tr_ref_if u_refs ();

  assign u_refs.ref_in = i_timing_reference_inputs;
  assign u_refs.enable = st.loop_on;

  tr_ref_monitor #(
    .TIMEOUT_CYC(REF_TIMEOUT_CYC)
  ) u_mon (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .refs(u_refs)
  );

  // ************************************************************
  // Register helpers
  // ************************************************************
  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return w == tr_pkg::REG_CTRL || w == tr_pkg::REG_REF_CHANGE ||
      w == tr_pkg::REG_STATUS || w == tr_pkg::REG_INT_STAT ||
      w == tr_pkg::REG_INT_MASK;
  endfunction

  function automatic logic [31:0] rd_reg(input tr_top_s s,
                                         input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case ({a[7:2], 2'b00})
      tr_pkg::REG_CTRL: begin
        v[tr_pkg::CTRL_MODE_LSB +: 2] = s.mode;
        v[tr_pkg::CTRL_CK3_LSB +: 2] = s.ck3_sel;
        v[tr_pkg::CTRL_CK4_BIT] = s.ck4_sel;
        v[tr_pkg::CTRL_SLE_BIT] = s.sle;
      end
      tr_pkg::REG_REF_CHANGE: begin
        v[tr_pkg::RCC_PREF_LSB +: 2] = s.pref;
        v[tr_pkg::RCC_FORCE_BIT] = s.force_ref;
      end
      tr_pkg::REG_STATUS: begin
        v[tr_pkg::STAT_FAIL_LSB +: 4] = s.fail_out;
        v[tr_pkg::STAT_SEL_LSB +: 2] = s.sel;
        v[tr_pkg::STAT_OSC_BIT] = s.osc_src;
        v[tr_pkg::STAT_4M_LSB +: 2] = i_four_meg_clock_select;
        v[tr_pkg::STAT_LOOP_BIT] = s.loop_on;
      end
      tr_pkg::REG_INT_STAT: v[3:0] = s.int_stat;
      tr_pkg::REG_INT_MASK: v[3:0] = s.int_mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] nco_step(input int i,
                                           input logic [1:0] ck3,
                                           input logic ck4);
    case (i)
      0: return tr_pkg::INC_4M096;
      1: return tr_pkg::INC_8M192;
      2: return tr_pkg::INC_16M384;
      3: begin
        case (ck3)
          tr_pkg::CK3_4M: return tr_pkg::INC_4M096;
          tr_pkg::CK3_8M: return tr_pkg::INC_8M192;
          tr_pkg::CK3_16M: return tr_pkg::INC_16M384;
          default: return tr_pkg::INC_32M768;
        endcase
      end
      4: return ck4 ? tr_pkg::INC_2M048 : tr_pkg::INC_1M544;
      default: return tr_pkg::INC_19M44;
    endcase
  endfunction

  function automatic logic [15:0] fp_base(input int i,
                                          input logic [1:0] ck3);
    case (i)
      0: return tr_pkg::FPW_4M096;
      1: return tr_pkg::FPW_8M192;
      2: return tr_pkg::FPW_16M384;
      default: begin
        case (ck3)
          tr_pkg::CK3_4M: return tr_pkg::FPW_4M096;
          tr_pkg::CK3_8M: return tr_pkg::FPW_8M192;
          tr_pkg::CK3_16M: return tr_pkg::FPW_16M384;
          default: return tr_pkg::FPW_32M768;
        endcase
      end
    endcase
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [31:0] wv;
    logic [3:0] w1c;
    logic [3:0] ev;
    logic boundary;
    logic found;
    logic [1:0] cand;
    logic [15:0] wid;
    wv = 32'h0000_0000;
    w1c = 4'h0;
    ev = 4'h0;
    boundary = 1'b0;
    found = 1'b0;
    cand = 2'h0;
    wid = 16'h0000;
    next_st = st;
    // Write channel: address and data in either order
    if (i_s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_s_axi_wdata;
      next_st.wstrb = i_s_axi_wstrb;
    end
    if (st.bvalid && i_s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.awaddr) ? tr_pkg::RESP_OKAY :
        tr_pkg::RESP_SLVERR;
      wv = rd_reg(st, st.awaddr);
      for (int b = 0; b < 4; b++) begin
        if (st.wstrb[b]) begin
          wv[b*8 +: 8] = st.wdata[b*8 +: 8];
        end
      end
      case ({st.awaddr[7:2], 2'b00})
        tr_pkg::REG_CTRL: begin
          next_st.mode = wv[tr_pkg::CTRL_MODE_LSB +: 2];
          next_st.ck3_sel = wv[tr_pkg::CTRL_CK3_LSB +: 2];
          next_st.ck4_sel = wv[tr_pkg::CTRL_CK4_BIT];
          next_st.sle = wv[tr_pkg::CTRL_SLE_BIT];
        end
        tr_pkg::REG_REF_CHANGE: begin
          next_st.pref = wv[tr_pkg::RCC_PREF_LSB +: 2];
          next_st.force_ref = wv[tr_pkg::RCC_FORCE_BIT];
        end
        tr_pkg::REG_INT_STAT: w1c = st.wdata[3:0] & {4{st.wstrb[0]}};
        tr_pkg::REG_INT_MASK: next_st.int_mask = wv[3:0];
        default: w1c = 4'h0;
      endcase
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    // Read channel: data one cycle after the address is taken
    if (st.rvalid && i_s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_reg(st, i_s_axi_araddr);
      next_st.rresp = is_mapped(i_s_axi_araddr) ? tr_pkg::RESP_OKAY :
        tr_pkg::RESP_SLVERR;
    end
    next_st.arready = !next_st.rvalid;
    // Reference path
    next_st.loop_on = next_st.mode == tr_pkg::MODE_MASTER || next_st.sle;
    ev = u_refs.fail & ~st.fail_prev;
    next_st.fail_prev = u_refs.fail;
    next_st.fail_out = next_st.loop_on ? u_refs.fail : 4'h0;
    next_st.int_stat = (st.int_stat & ~w1c) | ev;
    next_st.irq = |(next_st.int_stat & next_st.int_mask);
    // Preferred falls over to the next good reference; forced never does
    next_st.sel = next_st.pref;
    if (!next_st.force_ref && u_refs.fail[next_st.pref]) begin
      for (int k = 1; k < 4; k++) begin
        cand = next_st.pref + 2'(k);
        if (!found && !u_refs.fail[cand]) begin
          found = 1'b1;
          next_st.sel = cand;
        end
      end
    end
    next_st.osc_src = i_oscillator_present;
    // Frame timing: free-running in master, input pulse in slave
    next_st.fpi_prev = i_frame_pulse_input;
    if (i_frame_pulse_input) begin
      next_st.fpi_hi = !st.fpi_prev ? 8'h01 :
        (st.fpi_hi == tr_pkg::FPI_WIDTH_MAX ? st.fpi_hi : st.fpi_hi + 8'h01);
    end else if (st.fpi_prev) begin
      next_st.fpi_width = st.fpi_hi;
    end
    if (st.mode == tr_pkg::MODE_MASTER) begin
      boundary = st.frame_cnt == tr_pkg::FRAME_LAST;
    end else begin
      boundary = i_frame_pulse_input && !st.fpi_prev;
    end
    next_st.frame_cnt = boundary ? 14'h0000 : st.frame_cnt + 14'h0001;
    for (int i = 0; i < 6; i++) begin
      if (boundary) begin
        next_st.acc[i] = 32'h0000_0000;
      end else begin
        next_st.acc[i] = st.acc[i] + nco_step(i, st.ck3_sel, st.ck4_sel);
      end
      if (i >= 4 && !next_st.loop_on) begin
        next_st.acc[i] = 32'h0000_0000;
      end
      next_st.clk_out[i] = next_st.acc[i][31];
    end
    for (int i = 0; i < 4; i++) begin
      wid = fp_base(i, st.ck3_sel);
      if (st.mode == tr_pkg::MODE_DIV_SLAVE &&
          {8'h00, st.fpi_width} > wid) begin
        wid = {8'h00, st.fpi_width};
      end
      if (boundary) begin
        next_st.fp_cnt[i] = wid;
      end else if (st.fp_cnt[i] != 16'h0000) begin
        next_st.fp_cnt[i] = st.fp_cnt[i] - 16'h0001;
      end
      next_st.fp_out[i] = next_st.fp_cnt[i] != 16'h0000;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '0;
      st.mode <= tr_pkg::CTRL_RST[tr_pkg::CTRL_MODE_LSB +: 2];
      st.pref <= tr_pkg::RCC_RST[tr_pkg::RCC_PREF_LSB +: 2];
      st.int_mask <= tr_pkg::MASK_RST;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_s_axi_awready = st.awready;
  assign o_s_axi_wready = st.wready;
  assign o_s_axi_bresp = st.bresp;
  assign o_s_axi_bvalid = st.bvalid;
  assign o_s_axi_arready = st.arready;
  assign o_s_axi_rdata = st.rdata;
  assign o_s_axi_rresp = st.rresp;
  assign o_s_axi_rvalid = st.rvalid;
  assign o_reference_failure_outputs = st.fail_out;
  assign o_generated_clock_outputs = st.clk_out;
  assign o_frame_pulse_outputs = st.fp_out;
  assign o_selected_ref = st.sel;
  assign o_master_clk_from_osc = st.osc_src;
  assign o_irq = st.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [15:0] hlp_len;
  logic slave_quiet;

  assign slave_quiet = st.mode != tr_pkg::MODE_MASTER && !st.sle;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hlp_len <= 16'h0000;
    end else if (i_clk_en) begin
      hlp_len <= o_frame_pulse_outputs[2] ? hlp_len + 16'h0001 : 16'h0000;
    end
  end

  chk_fail_slave_low: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    slave_quiet |-> o_reference_failure_outputs == 4'h0)
    else $error("failure output high in quiet slave mode");
  chk_ck45_gated: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    slave_quiet |-> o_generated_clock_outputs[5:4] == 2'h0)
    else $error("clock 4 or 5 running in quiet slave mode");
  chk_fp_frame_start: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    $rose(o_frame_pulse_outputs[0]) && st.mode == tr_pkg::MODE_MASTER
    |-> st.frame_cnt == 14'h0000 && !o_generated_clock_outputs[0])
    else $error("frame pulse 0 not on frame boundary");
  chk_fp2_width: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    $rose(o_frame_pulse_outputs[2]) && $past(st.mode) == tr_pkg::MODE_MASTER
    |-> o_frame_pulse_outputs[2] [*7] ##1 !o_frame_pulse_outputs[2])
    else $error("frame pulse 2 not one 16 MHz period wide");
  chk_fp3_rate: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    $rose(o_frame_pulse_outputs[3]) &&
    $past(st.mode) == tr_pkg::MODE_MASTER &&
    $past(st.ck3_sel) == tr_pkg::CK3_32M
    |-> o_frame_pulse_outputs[3] [*4] ##1 !o_frame_pulse_outputs[3])
    else $error("frame pulse 3 width wrong for 32 MHz");
  chk_fp_not_narrow: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    $fell(o_frame_pulse_outputs[2]) && st.mode == tr_pkg::MODE_DIV_SLAVE
    |-> hlp_len >= {8'h00, st.fpi_width})
    else $error("frame pulse narrower than input pulse");
  chk_sel_forced: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    st.force_ref |-> o_selected_ref == st.pref)
    else $error("forced reference not selected");
  chk_osc_source: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    $changed(i_oscillator_present)
    |=> o_master_clk_from_osc == $past(i_oscillator_present))
    else $error("master clock source did not follow strap");
  cov_master_frame: cover property (@(posedge i_ref_clk)
    disable iff (i_reset) $rose(o_frame_pulse_outputs[0]));
  cov_slave_frame: cover property (@(posedge i_ref_clk)
    disable iff (i_reset)
    st.mode == tr_pkg::MODE_DIV_SLAVE && $rose(o_frame_pulse_outputs[1]));
  cov_irq: cover property (@(posedge i_ref_clk)
    disable iff (i_reset) $rose(o_irq));

endmodule // tr_timing_top

// ==== hw/tr_pkg.sv ====
// Constants, register map and rate tables for the timing reference block
//   Contract
// - each reference accepts any of seven listed rates
// - exactly one reference preferred or forced, software chosen
// - slave mode ignores references unless slave loop enabled
// - master mode: failed reference drives its failure output high
// - slave mode holds failure outputs low unless loop enabled
// - oscillator present selects oscillator, else TDM input clock
// - frame pulses 0-2 aligned to 4/8/16 MHz clocks
// - frame pulse 3 follows programmed clock 3 rate
// - divided slave pulses never narrower than input pulse; code measures input width only up to 255 cycles (FPI_WIDTH_MAX)
// - clocks 4, 5 run only master or loop enabled
package tr_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam longint CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_NS = 125_000;
  localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
  localparam logic [13:0] FRAME_LAST = 14'(FRAME_CYC - 1);
  localparam int REF_TIMEOUT_NS = 250_000;
  localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] FPI_WIDTH_MAX = 8'hFF;

  localparam longint F_1M544 = 1_544_000;
  localparam longint F_2M048 = 2_048_000;
  localparam longint F_4M096 = 4_096_000;
  localparam longint F_8M192 = 8_192_000;
  localparam longint F_16M384 = 16_384_000;
  localparam longint F_32M768 = 32_768_000;
  localparam longint F_19M44 = 19_440_000;

  // Phase step of a 32-bit accumulator for a given output rate
  function automatic logic [31:0] nco_inc(input longint hz);
    return 32'((hz << 32) / CLK_HZ);
  endfunction

  // One output clock period in whole cycles, rounded up
  function automatic logic [15:0] pulse_cyc(input longint hz);
    return 16'((CLK_HZ + hz - 1) / hz);
  endfunction

  localparam logic [31:0] INC_1M544 = nco_inc(F_1M544);
  localparam logic [31:0] INC_2M048 = nco_inc(F_2M048);
  localparam logic [31:0] INC_4M096 = nco_inc(F_4M096);
  localparam logic [31:0] INC_8M192 = nco_inc(F_8M192);
  localparam logic [31:0] INC_16M384 = nco_inc(F_16M384);
  localparam logic [31:0] INC_32M768 = nco_inc(F_32M768);
  localparam logic [31:0] INC_19M44 = nco_inc(F_19M44);
  localparam logic [15:0] FPW_4M096 = pulse_cyc(F_4M096);
  localparam logic [15:0] FPW_8M192 = pulse_cyc(F_8M192);
  localparam logic [15:0] FPW_16M384 = pulse_cyc(F_16M384);
  localparam logic [15:0] FPW_32M768 = pulse_cyc(F_32M768);

  // ************************************************************
  // Modes and selections
  // ************************************************************
  localparam logic [1:0] MODE_MASTER = 2'h0;
  localparam logic [1:0] MODE_DIV_SLAVE = 2'h1;
  localparam logic [1:0] MODE_MUL_SLAVE = 2'h2;
  localparam logic [1:0] CK3_4M = 2'h0;
  localparam logic [1:0] CK3_8M = 2'h1;
  localparam logic [1:0] CK3_16M = 2'h2;
  localparam logic [1:0] CK3_32M = 2'h3;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REF_CHANGE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0C;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CK3_LSB = 4;
  localparam int CTRL_CK4_BIT = 6;
  localparam int CTRL_SLE_BIT = 13;
  localparam int RCC_PREF_LSB = 0;
  localparam int RCC_FORCE_BIT = 2;
  localparam int STAT_FAIL_LSB = 0;
  localparam int STAT_SEL_LSB = 4;
  localparam int STAT_OSC_BIT = 6;
  localparam int STAT_4M_LSB = 7;
  localparam int STAT_LOOP_BIT = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RCC_RST = 32'h0000_0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== hw/tr_ref_if.sv ====
// Carrier between the top and the reference activity monitor
`timescale 1ns/100ps
interface tr_ref_if;
  logic [3:0] ref_in;
  logic enable;
  logic [3:0] fail;
  modport mon (input ref_in, input enable, output fail);
  modport top (output ref_in, output enable, input fail);
endinterface

// ==== hw/tr_ref_monitor.sv ====
// Per-reference activity monitor flagging a reference with no edges
`timescale 1ns/100ps
module tr_ref_monitor #(
  parameter int TIMEOUT_CYC = tr_pkg::REF_TIMEOUT_CYC,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Monitor side
  tr_ref_if.mon refs
);

  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << CNT_W)) begin : g_chk
    $error("tr_ref_monitor: TIMEOUT_CYC out of range");
  end

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

  typedef struct packed {
    logic [3:0] prev;
    logic [3:0][CNT_W-1:0] cnt;
    logic [3:0] fail;
  } tr_mon_s;

  tr_mon_s st;
  tr_mon_s next_st;
  logic [3:0] edge_seen;

  assign edge_seen = refs.ref_in & ~st.prev;
  assign refs.fail = st.fail;

  always_comb begin
    next_st = st;
    next_st.prev = refs.ref_in;
    for (int i = 0; i < 4; i++) begin
      if (!refs.enable) begin
        next_st.cnt[i] = '0;
        next_st.fail[i] = 1'b0;
      end else if (edge_seen[i]) begin
        // Any rising edge counts, so every listed rate is accepted
        next_st.cnt[i] = '0;
        next_st.fail[i] = 1'b0;
      end else if (st.cnt[i] == LAST) begin
        next_st.fail[i] = 1'b1;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_fail_on_timeout: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    refs.enable && st.cnt[0] == LAST && !edge_seen[0] |=> st.fail[0])
    else $error("reference 0 timeout did not raise failure");
  chk_fail_clears: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    st.fail[1] && edge_seen[1] |=> !st.fail[1] && st.cnt[1] == '0)
    else $error("reference 1 failure did not clear on edge");
  chk_disabled_quiet: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    !refs.enable |=> st.fail == 4'h0)
    else $error("failure flagged while references ignored");
  cov_ref_fails: cover property (@(posedge i_ref_clk)
    disable iff (i_reset) $rose(st.fail[2]));

endmodule // tr_ref_monitor

// ==== dv/tr_ref_model.sv ====
// Timing sources driving the references and the frame pulse input
`timescale 1ns/100ps
module tr_ref_model (
  // Clock
  input wire logic i_ref_clk,
  // Per-reference run control
  input wire logic [3:0] i_run,
  // Sources
  output logic [3:0] o_refs,
  output logic o_fp
);
  logic [3:0] cnt = 4'h0;
  initial o_refs = 4'h0;
  initial o_fp = 1'b0;
  always @(posedge i_ref_clk) begin
    cnt <= cnt + 4'h1;
    // Stopped reference sits low, no edges
    o_refs <= i_run & {4{cnt[2]}};
    o_fp <= (cnt == 4'h0);
  end
endmodule // tr_ref_model

// ==== dv/tb.sv ====
// Self-checking bench for the timing reference block
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } tr_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awr, wrdy, bv, arr, rv, frame_pulse_input, from_osc, irq;
  logic [1:0] bresp, rresp, sel, resp;
  logic [3:0] run = 4'hF, refs, fail, fpo;
  logic [5:0] cko;
  logic osc = 1'b1;
  int err_count = 0, cmp_count = 0, n [4];
  tr_row_s rows [8] = '{
    '{1'b0, tr_pkg::REG_CTRL, 32'h0, 2'h0},
    '{1'b0, tr_pkg::REG_REF_CHANGE, 32'h0, 2'h0},
    '{1'b0, tr_pkg::REG_INT_MASK, 32'h0, 2'h0},
    '{1'b1, tr_pkg::REG_REF_CHANGE, 32'h6, 2'h0},
    '{1'b0, tr_pkg::REG_REF_CHANGE, 32'h6, 2'h0},
    '{1'b1, tr_pkg::REG_STATUS, 32'hF, 2'h0},
    '{1'b1, 8'h20, 32'h1, 2'h2},
    '{1'b0, 8'h20, 32'h0, 2'h2}};
  always #5 clk = ~clk;
  tr_ref_model u_src (.i_ref_clk(clk), .i_run(run), .o_refs(refs),
    .o_fp(frame_pulse_input));
  tr_timing_top #(.REF_TIMEOUT_CYC(50)) u_dut (
    .i_ref_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
    .i_timing_reference_inputs(refs), .i_oscillator_present(osc),
    .i_four_meg_clock_select(2'h3),
    .i_frame_pulse_input(frame_pulse_input), .o_reference_failure_outputs(fail),
    .o_generated_clock_outputs(cko), .o_frame_pulse_outputs(fpo),
    .o_selected_ref(sel), .o_master_clk_from_osc(from_osc),
    .o_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ag, wg, bg;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    {ag, wg, bg} = 3'h7;
    while (ag | wg | bg) begin
      @(posedge clk);
      if (ag && awr === 1'b1) begin awv <= 1'b0; ag = 1'b0; end
      if (wg && wrdy === 1'b1) begin wv <= 1'b0; wg = 1'b0; end
      if (bg && bv === 1'b1) begin resp = bresp; bre <= 1'b0; bg = 1'b0; end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ag, rg;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    {ag, rg} = 2'h3;
    while (ag | rg) begin
      @(posedge clk);
      if (ag && arr === 1'b1) begin arv <= 1'b0; ag = 1'b0; end
      if (rg && rv === 1'b1) begin
        d = rdata;
        resp = rresp;
        rre <= 1'b0;
        rg = 1'b0;
      end
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  initial begin
    tick(40000);
    err_count++;
    summarize();
  end
  initial begin
    tick(5);
    rst <= 1'b0;
    tick(2);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a);
        chk(d, rows[i].d);
      end
      chk(32'(resp), 32'(rows[i].r));
    end
    chk(32'(sel), 32'h2);
    chk(32'(from_osc), 32'h1);
    run <= 4'hD;
    tick(80);
    chk(32'(fail), 32'h2);
    chk(32'(irq), 32'h0);
    wr(tr_pkg::REG_INT_MASK, 32'hF);
    tick(1);
    chk(32'(irq), 32'h1);
    wr(tr_pkg::REG_INT_STAT, 32'h2);
    tick(1);
    chk(32'(irq), 32'h0);
    run <= 4'hF;
    tick(20);
    chk(32'(fail), 32'h0);
    wr(tr_pkg::REG_CTRL, 32'h1);
    // Oscillator strap may only drop outside master mode
    osc <= 1'b0;
    tick(2);
    chk(32'(from_osc), 32'h0);
    osc <= 1'b1;
    run <= 4'hE;
    tick(80);
    chk(32'(fail), 32'h0);
    chk(32'(cko[5:4]), 32'h0);
    wr(tr_pkg::REG_CTRL, 32'h2001);
    tick(80);
    chk(32'(fail), 32'h1);
    n = '{default: 0};
    repeat (20) begin
      @(posedge clk);
      n[0] += cko[5];
    end
    chk(32'(n[0] > 0), 32'h1);
    wr(tr_pkg::REG_CTRL, 32'h30);
    run <= 4'hF;
    n = '{default: 0};
    // Wait for a fresh frame start
    while (!(fpo[0] === 1'b1 && n[1] == 1) && n[0] < 26000) begin
      n[1] = (fpo[0] === 1'b0);
      @(posedge clk);
      n[0]++;
    end
    chk(32'(cko), 32'h0);
    n = '{default: 0};
    repeat (40) begin
      foreach (n[k]) n[k] += fpo[k];
      @(posedge clk);
    end
    chk(n[0], 25);
    chk(n[1], 13);
    chk(n[2], 7);
    chk(n[3], 4);
    summarize();
  end
endmodule // tb
